// ==== rtl/bwu_params.svh ====
// Register indices, field positions and reset values of the debug comparators
`ifndef BWU_PARAMS_SVH
`define BWU_PARAMS_SVH

// Word indices; the APB byte address is four times the index
`define BWU_IDX_CAUSE 8'h15
`define BWU_IDX_DATA 8'h16
`define BWU_IDX_IBP_ADDR 8'h30
`define BWU_IDX_IBP_CTRL 8'h40
`define BWU_IDX_DWP_FIRST 8'h50
`define BWU_IDX_DWP_SECOND 8'h60
`define BWU_IDX_DWP_CTRL 8'h70
`define BWU_IDX_RWP_MASK 8'h80
`define BWU_IDX_RWP_VALUE 8'h90
`define BWU_IDX_RWP_CTRL 8'h9C

// Word index taken from APB byte address bits
`define BWU_PADDR_W 12
`define BWU_IDX_LSB 2
`define BWU_IDX_MSB 9

// Control register fields
`define BWU_CTL_EN 0
`define BWU_CTL_INV 1
`define BWU_CTL_LOAD 2
`define BWU_CTL_CORE_LSB 16
`define BWU_CTL_CORE_MSB 23
`define BWU_IBP_CTL_MASK 32'h00FF0003
`define BWU_DWP_CTL_MASK 32'h00FF0007
`define BWU_RWP_CTL_MASK 32'h00FF0003
`define BWU_CTL_RESET 32'h00000000
`define BWU_REG_RESET 32'h00000000

// Cause register fields
`define BWU_CAUSE_LSB 0
`define BWU_CAUSE_MSB 2
`define BWU_CORE_LSB 8
`define BWU_CORE_MSB 15
`define BWU_NUM_LSB 16
`define BWU_NUM_MSB 17
`define BWU_CAUSE_MASK 32'h0003FF07

// Comparator counts and core id width
`define BWU_NCMP 4
`define BWU_CORE_W 3

`endif

// ==== rtl/bwu_pkg.sv ====
// Types shared by the breakpoint and watchpoint unit
package bwu_pkg;

  typedef enum logic [2:0] {
    BWU_CAUSE_NONE = 3'h0,
    BWU_CAUSE_HOST = 3'h1,
    BWU_CAUSE_CALL = 3'h2,
    BWU_CAUSE_IBP = 3'h3,
    BWU_CAUSE_DWP = 3'h4,
    BWU_CAUSE_RWP = 3'h5
  } bwu_cause_t;

  typedef logic [1:0] bwu_num_t;

endpackage : bwu_pkg

// ==== rtl/bwu_top.sv ====
// Breakpoint and watchpoint comparators with APB register access
// Summary of operation
// [R1] Each instruction breakpoint holds a 32-bit address; PC equal fires.
// [R2] Four instruction breakpoints, each with own address and control.
// [R3] Invert bit set fires on PC not equal; cleared fires on equality.
// [R4] Control bits 23:16 qualify each logical core; reset to zero.
// [R5] Control bit 0 enables the comparator; disabled never fires.
// [R6] Each data watchpoint stores a 32-bit first bound.
// [R7] Each data watchpoint stores a 32-bit second bound.
// [R8] Each data watchpoint has its own control register.
// [R9] Bit 1 clear: fire when address lies within bounds inclusive.
// [R10] Bit 1 set: fire only strictly outside the bounds.
// [R11] Data watchpoints fire on loads only when control bit 2 set.
// [R12] Stores are always evaluated by enabled data watchpoints.
// [R13] Each resource watchpoint holds a 32-bit mask and match value.
// [R14] Bit 1 clear: fire when masked resource id equals value.
// [R15] Bit 1 set: fire when masked resource id differs from value.
// [R16] Four resource control registers in one consecutive block.
// [R17] Record cause 3, 4 or 5 for instruction, data, resource hit.
// [R18] Record comparator index in two bits; lowest index wins.
// [R19] Capture access address or resource id into debug data register.
// [R20] Addresses compare unsigned; comparators answer in the access cycle.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "bwu_params.svh"

module bwu_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`BWU_PADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Instruction fetch from the pipeline
  input wire logic pc_valid_in,
  input wire logic [31:0] pc_in,
  input wire logic [`BWU_CORE_W-1:0] pc_core_in,
  // Memory access from the pipeline
  input wire logic mem_valid_in,
  input wire logic mem_store_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [`BWU_CORE_W-1:0] mem_core_in,
  // Resource use from the pipeline
  input wire logic res_valid_in,
  input wire logic [31:0] res_id_in,
  input wire logic [`BWU_CORE_W-1:0] res_core_in,
  // Debug interrupt request and captured state
  output logic debug_irq_out,
  output logic [2:0] debug_cause_out,
  output logic [1:0] debug_num_out,
  output logic [31:0] debug_data_out
);

  logic [31:0] ibp_addr_reg [`BWU_NCMP];
  logic [31:0] ibp_ctrl_reg [`BWU_NCMP];
  logic [31:0] dwp_first_reg [`BWU_NCMP];
  logic [31:0] dwp_second_reg [`BWU_NCMP];
  logic [31:0] dwp_ctrl_reg [`BWU_NCMP];
  logic [31:0] rwp_mask_reg [`BWU_NCMP];
  logic [31:0] rwp_value_reg [`BWU_NCMP];
  logic [31:0] rwp_ctrl_reg [`BWU_NCMP];
  logic [31:0] cause_reg;
  logic [31:0] data_reg;
  logic irq_reg;

  logic [7:0] idx;
  logic [7:0] grp;
  logic [1:0] sub;
  logic mapped;
  logic wr_en;
  logic [`BWU_NCMP-1:0] ibp_hit;
  logic [`BWU_NCMP-1:0] dwp_hit;
  logic [`BWU_NCMP-1:0] rwp_hit;
  logic ibp_any;
  logic dwp_any;
  logic rwp_any;
  logic hit_any;
  bwu_pkg::bwu_num_t ibp_num;
  bwu_pkg::bwu_num_t dwp_num;
  bwu_pkg::bwu_num_t rwp_num;

  // APB decode
  assign idx = paddr_in[`BWU_IDX_MSB:`BWU_IDX_LSB];
  assign grp = {idx[7:2], 2'h0};
  assign sub = idx[1:0];
  always_comb begin
    unique case (grp)
      `BWU_IDX_IBP_ADDR, `BWU_IDX_IBP_CTRL,
      `BWU_IDX_DWP_FIRST, `BWU_IDX_DWP_SECOND, `BWU_IDX_DWP_CTRL,
      `BWU_IDX_RWP_MASK, `BWU_IDX_RWP_VALUE, `BWU_IDX_RWP_CTRL: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = (idx == `BWU_IDX_CAUSE) || (idx == `BWU_IDX_DATA);
      end
    endcase
  end
  assign wr_en = psel_in && penable_in && pwrite_in && mapped;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;

  always_comb begin
    prdata_out = 32'h00000000;
    if (idx == `BWU_IDX_CAUSE) begin
      prdata_out = cause_reg;
    end else if (idx == `BWU_IDX_DATA) begin
      prdata_out = data_reg;
    end else begin
      unique case (grp)
        `BWU_IDX_IBP_ADDR: prdata_out = ibp_addr_reg[sub];
        `BWU_IDX_IBP_CTRL: prdata_out = ibp_ctrl_reg[sub];
        `BWU_IDX_DWP_FIRST: prdata_out = dwp_first_reg[sub];
        `BWU_IDX_DWP_SECOND: prdata_out = dwp_second_reg[sub];
        `BWU_IDX_DWP_CTRL: prdata_out = dwp_ctrl_reg[sub];
        `BWU_IDX_RWP_MASK: prdata_out = rwp_mask_reg[sub];
        `BWU_IDX_RWP_VALUE: prdata_out = rwp_value_reg[sub];
        `BWU_IDX_RWP_CTRL: prdata_out = rwp_ctrl_reg[sub];
        default: prdata_out = 32'h00000000;
      endcase
    end
  end

  // Comparator registers and comparators, one set per index
  genvar i;
  generate
    for (i = 0; i < `BWU_NCMP; i++) begin : g_cmp
      logic dwp_inside;
      logic dwp_outside;

      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          ibp_addr_reg[i] <= `BWU_REG_RESET;
          ibp_ctrl_reg[i] <= `BWU_CTL_RESET; // R4 R5
          dwp_first_reg[i] <= `BWU_REG_RESET;
          dwp_second_reg[i] <= `BWU_REG_RESET;
          dwp_ctrl_reg[i] <= `BWU_CTL_RESET; // R11
          rwp_mask_reg[i] <= `BWU_REG_RESET;
          rwp_value_reg[i] <= `BWU_REG_RESET;
          rwp_ctrl_reg[i] <= `BWU_CTL_RESET;
        end else if (wr_en && sub == 2'(i)) begin
          unique case (grp)
            `BWU_IDX_IBP_ADDR: ibp_addr_reg[i] <= pwdata_in; // R1 R2
            `BWU_IDX_IBP_CTRL: begin
              ibp_ctrl_reg[i] <= pwdata_in & `BWU_IBP_CTL_MASK; // R2
            end
            `BWU_IDX_DWP_FIRST: dwp_first_reg[i] <= pwdata_in; // R6
            `BWU_IDX_DWP_SECOND: dwp_second_reg[i] <= pwdata_in; // R7
            `BWU_IDX_DWP_CTRL: begin
              dwp_ctrl_reg[i] <= pwdata_in & `BWU_DWP_CTL_MASK; // R8
            end
            `BWU_IDX_RWP_MASK: rwp_mask_reg[i] <= pwdata_in; // R13
            `BWU_IDX_RWP_VALUE: rwp_value_reg[i] <= pwdata_in; // R13
            `BWU_IDX_RWP_CTRL: begin
              rwp_ctrl_reg[i] <= pwdata_in & `BWU_RWP_CTL_MASK; // R16
            end
            default: ;
          endcase
        end
      end

      // Unsigned compare, combinational in the access cycle
      assign dwp_inside = (mem_addr_in >= dwp_first_reg[i]) &&
                          (mem_addr_in <= dwp_second_reg[i]); // R9 R20
      assign dwp_outside = (mem_addr_in < dwp_first_reg[i]) ||
                           (mem_addr_in > dwp_second_reg[i]); // R10 R20

      assign ibp_hit[i] = pc_valid_in &&
        ibp_ctrl_reg[i][`BWU_CTL_EN] &&
        ibp_ctrl_reg[i][`BWU_CTL_CORE_LSB + pc_core_in] &&
        ((pc_in == ibp_addr_reg[i]) ^
         ibp_ctrl_reg[i][`BWU_CTL_INV]); // R1 R3 R4 R5

      assign dwp_hit[i] = mem_valid_in &&
        dwp_ctrl_reg[i][`BWU_CTL_EN] &&
        dwp_ctrl_reg[i][`BWU_CTL_CORE_LSB + mem_core_in] &&
        (mem_store_in || dwp_ctrl_reg[i][`BWU_CTL_LOAD]) && // R11 R12
        (dwp_ctrl_reg[i][`BWU_CTL_INV] ?
         dwp_outside : dwp_inside); // R4 R5 R9 R10

      assign rwp_hit[i] = res_valid_in &&
        rwp_ctrl_reg[i][`BWU_CTL_EN] &&
        rwp_ctrl_reg[i][`BWU_CTL_CORE_LSB + res_core_in] &&
        (((res_id_in & rwp_mask_reg[i]) == rwp_value_reg[i]) ^
         rwp_ctrl_reg[i][`BWU_CTL_INV]); // R4 R5 R14 R15

      ibp_gate_a: assert property ( // R3
        @(posedge mclk_in) disable iff (reset_in)
        ibp_hit[i] |-> ibp_ctrl_reg[i][`BWU_CTL_EN] &&
          ibp_ctrl_reg[i][`BWU_CTL_CORE_LSB + pc_core_in] &&
          ((pc_in == ibp_addr_reg[i]) != ibp_ctrl_reg[i][`BWU_CTL_INV]))
        else $error("instruction breakpoint fired without its condition");
      dwp_load_a: assert property ( // R11
        @(posedge mclk_in) disable iff (reset_in)
        dwp_hit[i] && !mem_store_in |-> dwp_ctrl_reg[i][`BWU_CTL_LOAD])
        else $error("data watchpoint fired on a load while loads off");
      dwp_inside_a: assert property ( // R9
        @(posedge mclk_in) disable iff (reset_in)
        dwp_hit[i] && !dwp_ctrl_reg[i][`BWU_CTL_INV] |->
          mem_addr_in >= dwp_first_reg[i] &&
          mem_addr_in <= dwp_second_reg[i])
        else $error("inside watchpoint fired outside bounds");
      dwp_bound_a: assert property ( // R10
        @(posedge mclk_in) disable iff (reset_in)
        dwp_hit[i] && dwp_ctrl_reg[i][`BWU_CTL_INV] |->
          mem_addr_in != dwp_first_reg[i] &&
          mem_addr_in != dwp_second_reg[i])
        else $error("outside watchpoint fired on a bound");
      dwp_store_a: assert property ( // R12
        @(posedge mclk_in) disable iff (reset_in)
        mem_valid_in && mem_store_in && dwp_ctrl_reg[i][`BWU_CTL_EN] &&
          dwp_ctrl_reg[i][`BWU_CTL_CORE_LSB + mem_core_in] &&
          !dwp_ctrl_reg[i][`BWU_CTL_INV] &&
          mem_addr_in == dwp_first_reg[i] &&
          dwp_first_reg[i] <= dwp_second_reg[i] |-> dwp_hit[i])
        else $error("store on first bound missed");
      rwp_match_a: assert property ( // R15
        @(posedge mclk_in) disable iff (reset_in)
        rwp_hit[i] |-> (((res_id_in & rwp_mask_reg[i]) ==
          rwp_value_reg[i]) != rwp_ctrl_reg[i][`BWU_CTL_INV]))
        else $error("resource watchpoint match sense wrong");
      dwp_gate_a: assert property ( // R5
        @(posedge mclk_in) disable iff (reset_in)
        dwp_hit[i] |-> dwp_ctrl_reg[i][`BWU_CTL_EN] &&
          dwp_ctrl_reg[i][`BWU_CTL_CORE_LSB + mem_core_in])
        else $error("data watchpoint fired while not armed");
      rwp_gate_a: assert property ( // R4
        @(posedge mclk_in) disable iff (reset_in)
        rwp_hit[i] |-> rwp_ctrl_reg[i][`BWU_CTL_EN] &&
          rwp_ctrl_reg[i][`BWU_CTL_CORE_LSB + res_core_in])
        else $error("resource watchpoint fired while not armed");
      ibp_write_a: assert property ( // R1
        @(posedge mclk_in) disable iff (reset_in)
        wr_en && grp == `BWU_IDX_IBP_ADDR && sub == 2'(i) |=>
          ibp_addr_reg[i] == $past(pwdata_in))
        else $error("breakpoint address write lost");
      rwp_mask_a: assert property ( // R13
        @(posedge mclk_in) disable iff (reset_in)
        wr_en && grp == `BWU_IDX_RWP_MASK && sub == 2'(i) |=>
          rwp_mask_reg[i] == $past(pwdata_in))
        else $error("resource mask write lost");
    end
  endgenerate

  function automatic bwu_pkg::bwu_num_t bwu_lowest(
    input logic [`BWU_NCMP-1:0] hits
  );
    bwu_pkg::bwu_num_t n;
    n = 2'h0;
    for (int k = `BWU_NCMP - 1; k >= 0; k--) begin
      if (hits[k]) begin
        n = 2'(k);
      end
    end
    return n;
  endfunction : bwu_lowest

  assign ibp_any = |ibp_hit;
  assign dwp_any = |dwp_hit;
  assign rwp_any = |rwp_hit;
  assign hit_any = ibp_any || dwp_any || rwp_any;
  assign ibp_num = bwu_lowest(ibp_hit); // R18
  assign dwp_num = bwu_lowest(dwp_hit); // R18
  assign rwp_num = bwu_lowest(rwp_hit); // R18

  // Cause capture; a hit in the same cycle as a software write wins
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cause_reg <= `BWU_REG_RESET;
    end else if (ibp_any) begin
      cause_reg <= {14'h0000, ibp_num, 5'h00, pc_core_in,
                    5'h00, bwu_pkg::BWU_CAUSE_IBP}; // R17 R18
    end else if (dwp_any) begin
      cause_reg <= {14'h0000, dwp_num, 5'h00, mem_core_in,
                    5'h00, bwu_pkg::BWU_CAUSE_DWP}; // R17 R18
    end else if (rwp_any) begin
      cause_reg <= {14'h0000, rwp_num, 5'h00, res_core_in,
                    5'h00, bwu_pkg::BWU_CAUSE_RWP}; // R17 R18
    end else if (wr_en && idx == `BWU_IDX_CAUSE) begin
      cause_reg <= pwdata_in & `BWU_CAUSE_MASK;
    end
  end

  // Debug data capture
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      data_reg <= `BWU_REG_RESET;
    end else if (!ibp_any && dwp_any) begin
      data_reg <= mem_addr_in; // R19
    end else if (!ibp_any && rwp_any) begin
      data_reg <= res_id_in; // R19
    end else if (!ibp_any && wr_en && idx == `BWU_IDX_DATA) begin
      data_reg <= pwdata_in;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= hit_any; // R20
    end
  end

  assign debug_irq_out = irq_reg;
  assign debug_cause_out = cause_reg[`BWU_CAUSE_MSB:`BWU_CAUSE_LSB];
  assign debug_num_out = cause_reg[`BWU_NUM_MSB:`BWU_NUM_LSB];
  assign debug_data_out = data_reg;

  irq_next_a: assert property ( // R20
    @(posedge mclk_in) disable iff (reset_in)
    hit_any |=> debug_irq_out ##1 (debug_irq_out == $past(hit_any)))
    else $error("debug interrupt not raised after a hit");
  no_hit_a: assert property ( // R5
    @(posedge mclk_in) disable iff (reset_in)
    !hit_any |=> !debug_irq_out)
    else $error("debug interrupt raised with no hit");
  cause_ibp_a: assert property ( // R17
    @(posedge mclk_in) disable iff (reset_in)
    ibp_any |=> debug_cause_out == 3'h3 && debug_irq_out)
    else $error("instruction breakpoint cause wrong");
  cause_dwp_a: assert property ( // R19
    @(posedge mclk_in) disable iff (reset_in)
    !ibp_any && dwp_any |=> debug_cause_out == 3'h4 &&
      debug_data_out == $past(mem_addr_in))
    else $error("data watchpoint cause or address wrong");
  cause_rwp_a: assert property ( // R17
    @(posedge mclk_in) disable iff (reset_in)
    !ibp_any && !dwp_any && rwp_any |=> debug_cause_out == 3'h5 &&
      debug_data_out == $past(res_id_in))
    else $error("resource watchpoint cause or id wrong");
  lowest_num_a: assert property ( // R18
    @(posedge mclk_in) disable iff (reset_in)
    ibp_hit[0] |=> debug_num_out == 2'h0)
    else $error("lowest breakpoint index not reported");
  ibp_one_a: assert property ( // R2
    @(posedge mclk_in) disable iff (reset_in)
    ibp_hit[3] && !ibp_hit[0] && !ibp_hit[1] && !ibp_hit[2]
      |=> debug_num_out == 2'h3)
    else $error("breakpoint index three not reported");
  dwp_num_a: assert property ( // R18
    @(posedge mclk_in) disable iff (reset_in)
    !ibp_any && dwp_hit[0] |=> debug_num_out == 2'h0)
    else $error("lowest watchpoint index not reported");
  rwp_num_a: assert property ( // R18
    @(posedge mclk_in) disable iff (reset_in)
    !ibp_any && !dwp_any && rwp_hit[0] |=> debug_num_out == 2'h0)
    else $error("lowest resource index not reported");
  irq_cause_a: assert property ( // R17
    @(posedge mclk_in) disable iff (reset_in)
    debug_irq_out |-> debug_cause_out inside {3'h3, 3'h4, 3'h5})
    else $error("debug interrupt without a comparator cause");
  data_hold_a: assert property ( // R19
    @(posedge mclk_in) disable iff (reset_in)
    ibp_any |=> debug_data_out == $past(data_reg))
    else $error("debug data changed on a breakpoint");

  ibp_hit_c: cover property (@(posedge mclk_in) disable iff (reset_in)
    ibp_any ##1 debug_irq_out);
  dwp_load_c: cover property (@(posedge mclk_in) disable iff (reset_in)
    dwp_any && !mem_store_in);
  dwp_out_c: cover property (@(posedge mclk_in) disable iff (reset_in)
    dwp_hit[1] && dwp_ctrl_reg[1][`BWU_CTL_INV]);
  rwp_inv_c: cover property (@(posedge mclk_in) disable iff (reset_in)
    rwp_hit[2] && rwp_ctrl_reg[2][`BWU_CTL_INV]);
  multi_c: cover property (@(posedge mclk_in) disable iff (reset_in)
    ibp_hit[1] && ibp_hit[2]);

endmodule : bwu_top

// ==== verification/bwu_core_model.sv ====
// Pipeline model issuing fetches, memory accesses and resource uses
`timescale 1ns/1ps

module bwu_core_model (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Commands from the bench: kind 0 fetch, 1 memory, 2 resource
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_kind_in,
  input wire logic [31:0] cmd_value_in,
  input wire logic [2:0] cmd_core_in,
  input wire logic cmd_store_in,
  // Pipeline streams into the unit
  output logic pc_valid_out,
  output logic [31:0] pc_out,
  output logic [2:0] pc_core_out,
  output logic mem_valid_out,
  output logic mem_store_out,
  output logic [31:0] mem_addr_out,
  output logic [2:0] mem_core_out,
  output logic res_valid_out,
  output logic [31:0] res_id_out,
  output logic [2:0] res_core_out
);
  logic [2:0] sel;

  always_comb begin
    sel[0] = cmd_valid_in && cmd_kind_in == 2'h0;
    sel[1] = cmd_valid_in && cmd_kind_in == 2'h1;
    sel[2] = cmd_valid_in && cmd_kind_in == 2'h2;
  end

  // Idle streams show inverted junk so no stale value looks valid
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_valid_out <= 1'b0;
      pc_out <= 32'h0;
      pc_core_out <= 3'h0;
      mem_valid_out <= 1'b0;
      mem_store_out <= 1'b0;
      mem_addr_out <= 32'h0;
      mem_core_out <= 3'h0;
      res_valid_out <= 1'b0;
      res_id_out <= 32'h0;
      res_core_out <= 3'h0;
    end else begin
      pc_valid_out <= sel[0];
      pc_out <= sel[0] ? cmd_value_in : ~pc_out;
      pc_core_out <= sel[0] ? cmd_core_in : ~pc_core_out;
      mem_valid_out <= sel[1];
      mem_store_out <= sel[1] ? cmd_store_in : ~mem_store_out;
      mem_addr_out <= sel[1] ? cmd_value_in : ~mem_addr_out;
      mem_core_out <= sel[1] ? cmd_core_in : ~mem_core_out;
      res_valid_out <= sel[2];
      res_id_out <= sel[2] ? cmd_value_in : ~res_id_out;
      res_core_out <= sel[2] ? cmd_core_in : ~res_core_out;
    end
  end
endmodule : bwu_core_model

// ==== verification/testbench.sv ====
// Self-checking bench for the breakpoint and watchpoint unit
`timescale 1ns/1ps
`include "bwu_params.svh"

module testbench;
  typedef struct packed {
    logic [1:0] kind;
    logic [31:0] val;
    logic [2:0] core;
    logic st;
    logic irq;
    logic [2:0] cause;
    logic [1:0] num;
  } bwu_row_t;
  localparam logic [7:0] CFG_I [20] = '{
    `BWU_IDX_IBP_ADDR, `BWU_IDX_IBP_ADDR + 8'h1,
    `BWU_IDX_IBP_ADDR + 8'h2, `BWU_IDX_IBP_ADDR + 8'h3,
    `BWU_IDX_IBP_CTRL, `BWU_IDX_IBP_CTRL + 8'h1,
    `BWU_IDX_IBP_CTRL + 8'h2, `BWU_IDX_IBP_CTRL + 8'h3,
    `BWU_IDX_DWP_FIRST, `BWU_IDX_DWP_FIRST + 8'h1,
    `BWU_IDX_DWP_SECOND, `BWU_IDX_DWP_SECOND + 8'h1,
    `BWU_IDX_DWP_CTRL, `BWU_IDX_DWP_CTRL + 8'h1,
    `BWU_IDX_RWP_MASK, `BWU_IDX_RWP_MASK + 8'h1,
    `BWU_IDX_RWP_VALUE, `BWU_IDX_RWP_VALUE + 8'h1,
    `BWU_IDX_RWP_CTRL, `BWU_IDX_RWP_CTRL + 8'h1};
  localparam logic [31:0] CFG_D [20] = '{
    32'h1000, 32'h2000, 32'h3000, 32'h1000,
    32'h00010001, 32'h00040003, 32'h00FF0000, 32'h00010001,
    32'h100, 32'h400, 32'h1FF, 32'h4FF, 32'h00020001, 32'h00100007,
    32'hFF00, 32'hFFFFFFFF, 32'h1200, 32'h55, 32'h00080001, 32'h00200003};
  localparam bwu_row_t ROWS [19] = '{
    '{2'h0, 32'h1000, 3'h0, 1'b0, 1'b1, 3'h3, 2'h0},
    '{2'h0, 32'h1000, 3'h1, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h0, 32'h1004, 3'h0, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h0, 32'h3000, 3'h0, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h0, 32'h2000, 3'h2, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h0, 32'h2004, 3'h2, 1'b0, 1'b1, 3'h3, 2'h1},
    '{2'h1, 32'h100, 3'h1, 1'b1, 1'b1, 3'h4, 2'h0},
    '{2'h1, 32'h1FF, 3'h1, 1'b1, 1'b1, 3'h4, 2'h0},
    '{2'h1, 32'h200, 3'h1, 1'b1, 1'b0, 3'h0, 2'h0},
    '{2'h1, 32'h150, 3'h1, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h1, 32'h3FF, 3'h4, 1'b0, 1'b1, 3'h4, 2'h1},
    '{2'h1, 32'h400, 3'h4, 1'b1, 1'b0, 3'h0, 2'h0},
    '{2'h1, 32'h4FF, 3'h4, 1'b1, 1'b0, 3'h0, 2'h0},
    '{2'h1, 32'h500, 3'h4, 1'b0, 1'b1, 3'h4, 2'h1},
    '{2'h1, 32'hFFFFFFFF, 3'h4, 1'b1, 1'b1, 3'h4, 2'h1},
    '{2'h2, 32'h12AB, 3'h3, 1'b0, 1'b1, 3'h5, 2'h0},
    '{2'h2, 32'h13AB, 3'h3, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h2, 32'h55, 3'h5, 1'b0, 1'b0, 3'h0, 2'h0},
    '{2'h2, 32'h56, 3'h5, 1'b0, 1'b1, 3'h5, 2'h1}};

  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic pc_valid_in, mem_valid_in, mem_store_in, res_valid_in;
  logic [31:0] pc_in, mem_addr_in, res_id_in;
  logic [2:0] pc_core_in, mem_core_in, res_core_in;
  logic debug_irq_out;
  logic [2:0] debug_cause_out;
  logic [1:0] debug_num_out;
  logic [31:0] debug_data_out;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [31:0] cmd_value = 32'h0;
  logic [2:0] cmd_core = 3'h0;
  logic cmd_store = 1'b0;
  logic [2:0] exp_cause = 3'h0;
  logic [1:0] exp_num = 2'h0;
  logic [31:0] exp_data = 32'h0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #50 mclk_in = ~mclk_in;

  bwu_top i_bwu_top (.mclk_in(mclk_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pc_valid_in(pc_valid_in), .pc_in(pc_in), .pc_core_in(pc_core_in),
    .mem_valid_in(mem_valid_in), .mem_store_in(mem_store_in),
    .mem_addr_in(mem_addr_in), .mem_core_in(mem_core_in),
    .res_valid_in(res_valid_in), .res_id_in(res_id_in),
    .res_core_in(res_core_in), .debug_irq_out(debug_irq_out),
    .debug_cause_out(debug_cause_out), .debug_num_out(debug_num_out),
    .debug_data_out(debug_data_out));

  bwu_core_model i_bwu_core_model (.mclk_in(mclk_in), .reset_in(reset_in),
    .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind),
    .cmd_value_in(cmd_value), .cmd_core_in(cmd_core),
    .cmd_store_in(cmd_store), .pc_valid_out(pc_valid_in), .pc_out(pc_in),
    .pc_core_out(pc_core_in), .mem_valid_out(mem_valid_in),
    .mem_store_out(mem_store_in), .mem_addr_out(mem_addr_in),
    .mem_core_out(mem_core_in), .res_valid_out(res_valid_in),
    .res_id_out(res_id_in), .res_core_out(res_core_in));

  task automatic give_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask : chk

  // Entered just after a rising edge; waits for pready without assuming
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, e, input logic err);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= {2'h0, idx, 2'h0};
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    @(posedge mclk_in);
    while (pready_out !== 1'b1) begin
      @(posedge mclk_in);
    end
    if (!wr) begin
      chk("prdata", e, prdata_out);
    end
    chk("pslverr", {31'h0, err}, {31'h0, pslverr_out});
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask : apb

  task automatic run(input bwu_row_t r);
    cmd_valid <= 1'b1;
    cmd_kind <= r.kind;
    cmd_value <= r.val;
    cmd_core <= r.core;
    cmd_store <= r.st;
    @(posedge mclk_in);
    cmd_valid <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in);
    if (r.irq) begin
      exp_cause = r.cause;
      exp_num = r.num;
      if (r.cause != 3'h3) begin
        exp_data = r.val;
      end
    end
    chk("irq", {31'h0, r.irq}, {31'h0, debug_irq_out});
    chk("cause", {29'h0, exp_cause}, {29'h0, debug_cause_out});
    chk("num", {30'h0, exp_num}, {30'h0, debug_num_out});
    chk("data", exp_data, debug_data_out);
    @(posedge mclk_in);
  endtask : run

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    apb(1'b0, `BWU_IDX_DWP_CTRL, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, CFG_I[i], CFG_D[i], 32'h0, 1'b0);
    end
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, CFG_I[i], 32'h0, CFG_D[i], 1'b0);
    end
    for (int i = 0; i < 19; i++) begin
      run(ROWS[i]);
    end
    apb(1'b0, `BWU_IDX_CAUSE, 32'h0, 32'h00010505, 1'b0);
    apb(1'b0, 8'hFF, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `BWU_IDX_DWP_CTRL + 8'h3, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b0, `BWU_IDX_DWP_CTRL + 8'h3, 32'h0, 32'h00FF0007, 1'b0);
    apb(1'b1, `BWU_IDX_DWP_CTRL + 8'h3, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `BWU_IDX_RWP_CTRL + 8'h3, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b0, `BWU_IDX_RWP_CTRL + 8'h3, 32'h0, 32'h00FF0003, 1'b0);
    apb(1'b1, `BWU_IDX_RWP_CTRL + 8'h3, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `BWU_IDX_CAUSE, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b0, `BWU_IDX_CAUSE, 32'h0, 32'h0003FF07, 1'b0);
    apb(1'b1, `BWU_IDX_DATA, 32'hA5A5A5A5, 32'h0, 1'b0);
    apb(1'b0, `BWU_IDX_DATA, 32'h0, 32'hA5A5A5A5, 1'b0);
    exp_data = 32'hA5A5A5A5;
    // Disabling breakpoint 0 leaves its twin at index 3 to answer
    apb(1'b1, `BWU_IDX_IBP_CTRL, 32'h00010000, 32'h0, 1'b0);
    run('{2'h0, 32'h1000, 3'h0, 1'b0, 1'b1, 3'h3, 2'h3});
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    chk("cause", 32'h0, {29'h0, debug_cause_out});
    chk("num", 32'h0, {30'h0, debug_num_out});
    chk("data", 32'h0, debug_data_out);
    chk("irq", 32'h0, {31'h0, debug_irq_out});
    apb(1'b0, `BWU_IDX_IBP_CTRL + 8'h3, 32'h0, 32'h0, 1'b0);
    give_verdict();
  end
endmodule : testbench
